// File: hdl/dpbr_defs.vh
// Constants for the dual-port block RAM and its register window
`ifndef DPBR_DEFS_VH
`define DPBR_DEFS_VH

// Array geometry
`define DPBR_DEPTH         256
`define DPBR_AW            8
`define DPBR_DW            16

// Register bus geometry
`define DPBR_BUS_AW        8
`define DPBR_BUS_DW        32

// Register byte offsets
`define DPBR_OFF_CTRL      8'h00
`define DPBR_OFF_LOAD_ADDR 8'h04
`define DPBR_OFF_LOAD_DATA 8'h08
`define DPBR_OFF_STATUS    8'h0c
`define DPBR_OFF_WR_COUNT  8'h10
`define DPBR_OFF_RD_COUNT  8'h14
`define DPBR_OFF_BLK_COUNT 8'h18

// Control field positions and reset value
`define DPBR_CTRL_WR_INV   0
`define DPBR_CTRL_RD_INV   1
`define DPBR_CTRL_CFG      2
`define DPBR_CTRL_W        3
`define DPBR_CTRL_RST      3'h0

// Status field positions
`define DPBR_STAT_CFG      0
`define DPBR_STAT_IDLE     1
`define DPBR_STAT_WR_INV   2
`define DPBR_STAT_RD_INV   3

// Counter width and reset values
`define DPBR_CNT_W         16
`define DPBR_CNT_RST       16'h0000
`define DPBR_ADDR_RST      8'h00

// Bus responses
`define DPBR_RESP_OKAY     2'h0
`define DPBR_RESP_SLVERR   2'h2

`endif

// File: hdl/dpbr_edge_detect.v
// Active-edge detector for a port clock sampled on the system clock
module dpbr_edge_detect
(
  // System
  input  wire aclk,
  input  wire aresetn,
  // Sampled port clock and polarity choice
  input  wire level_in,
  input  wire invert,
  // One-cycle pulse on the chosen edge
  output wire edge_pulse
);

  reg prev_reg;

  always @(posedge aclk)
  begin
    if (!aresetn)
      prev_reg <= 1'b0;
    else
      prev_reg <= level_in;
  end

  // Rising by default, falling when inverted
  assign edge_pulse = invert ? (prev_reg & ~level_in) : (~prev_reg & level_in);

endmodule // dpbr_edge_detect

// File: hdl/dpbr_block_ram.v
// Dual-port 256x16 block RAM with masked writes and an AXI4-Lite control window
`include "dpbr_defs.vh"

module dpbr_block_ram
(
  // System
  input  wire                         aclk,
  input  wire                         aresetn,
  // AXI4-Lite write address
  input  wire [`DPBR_BUS_AW-1:0]      s_axi_awaddr,
  input  wire                         s_axi_awvalid,
  output wire                         s_axi_awready,
  // AXI4-Lite write data
  input  wire [`DPBR_BUS_DW-1:0]      s_axi_wdata,
  input  wire [3:0]                   s_axi_wstrb,
  input  wire                         s_axi_wvalid,
  output wire                         s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]                   s_axi_bresp,
  output wire                         s_axi_bvalid,
  input  wire                         s_axi_bready,
  // AXI4-Lite read address
  input  wire [`DPBR_BUS_AW-1:0]      s_axi_araddr,
  input  wire                         s_axi_arvalid,
  output wire                         s_axi_arready,
  // AXI4-Lite read data
  output wire [`DPBR_BUS_DW-1:0]      s_axi_rdata,
  output wire [1:0]                   s_axi_rresp,
  output wire                         s_axi_rvalid,
  input  wire                         s_axi_rready,
  // Write port
  input  wire                         wr_clk,
  input  wire                         wr_clk_gate,
  input  wire                         wr_port_on,
  input  wire [`DPBR_AW-1:0]          wr_addr,
  input  wire [`DPBR_DW-1:0]          wr_data,
  input  wire [`DPBR_DW-1:0]          bit_write_inhibit,
  // Read port
  input  wire                         rd_clk,
  input  wire                         rd_clk_gate,
  input  wire                         rd_port_on,
  input  wire [`DPBR_AW-1:0]          rd_addr,
  output wire [`DPBR_DW-1:0]          rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Word-aligned register hit
  function hit;
    input [`DPBR_BUS_AW-1:0] addr;
    input [`DPBR_BUS_AW-1:0] offset;
    begin
      hit = (addr[`DPBR_BUS_AW-1:2] == offset[`DPBR_BUS_AW-1:2]);
    end
  endfunction

  // Byte-lane merge of a bus write into the low 16 bits of a register
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  strb;
    begin
      lane_merge = {(strb[1] ? new_val[15:8] : old_val[15:8]),
                    (strb[0] ? new_val[7:0]  : old_val[7:0])};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  // Deliberately no reset: contents survive a bus reset and reconfiguration
  reg  [`DPBR_DW-1:0]     mem [0:`DPBR_DEPTH-1];
  reg  [`DPBR_DW-1:0]     rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  reg  [`DPBR_CTRL_W-1:0] ctrl_reg;
  reg  [`DPBR_AW-1:0]     load_addr_reg;
  reg  [`DPBR_CNT_W-1:0]  wr_count_reg;
  reg  [`DPBR_CNT_W-1:0]  rd_count_reg;
  reg  [`DPBR_CNT_W-1:0]  blk_count_reg;

  wire wr_clk_inv = ctrl_reg[`DPBR_CTRL_WR_INV];
  wire rd_clk_inv = ctrl_reg[`DPBR_CTRL_RD_INV];
  wire cfg_mode   = ctrl_reg[`DPBR_CTRL_CFG];

  ////////////////////////////////////////////////////////////////////////////
  // Port clock edges

  wire [1:0] port_clk  = {rd_clk, wr_clk};
  wire [1:0] port_inv  = {rd_clk_inv, wr_clk_inv};
  wire [1:0] port_edge;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_edge
      dpbr_edge_detect u_edge
      (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .level_in   (port_clk[g]),
        .invert     (port_inv[g]),
        .edge_pulse (port_edge[g])
      );
    end
  endgenerate

  wire wr_edge = port_edge[0];
  wire rd_edge = port_edge[1];

  // A gated clock never reaches the array, so the edge is discarded here
  wire wr_req  = wr_edge & wr_clk_gate & wr_port_on;
  wire wr_do   = wr_req & ~cfg_mode;
  wire wr_blk  = wr_req & cfg_mode;
  wire rd_do   = rd_edge & rd_clk_gate & rd_port_on;

  // Bitwise merge: inhibited bits keep the stored value
  wire [`DPBR_DW-1:0] wr_old    = mem[wr_addr];
  wire [`DPBR_DW-1:0] wr_merged = (wr_old & bit_write_inhibit) |
                                  (wr_data & ~bit_write_inhibit);

  ////////////////////////////////////////////////////////////////////////////
  // Bus write channel

  reg                      aw_held_reg;
  reg  [`DPBR_BUS_AW-1:0]  aw_addr_reg;
  reg                      w_held_reg;
  reg  [`DPBR_BUS_DW-1:0]  w_data_reg;
  reg  [3:0]               w_strb_reg;
  reg                      bvalid_reg;
  reg  [1:0]               bresp_reg;

  // Address and data are taken in either order, then one response
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  wire bus_wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;

  wire wr_ctrl  = bus_wr_go & hit(aw_addr_reg, `DPBR_OFF_CTRL);
  wire wr_laddr = bus_wr_go & hit(aw_addr_reg, `DPBR_OFF_LOAD_ADDR);
  wire wr_ldata = bus_wr_go & hit(aw_addr_reg, `DPBR_OFF_LOAD_DATA);
  wire wr_wcnt  = bus_wr_go & hit(aw_addr_reg, `DPBR_OFF_WR_COUNT);
  wire wr_rcnt  = bus_wr_go & hit(aw_addr_reg, `DPBR_OFF_RD_COUNT);
  wire wr_bcnt  = bus_wr_go & hit(aw_addr_reg, `DPBR_OFF_BLK_COUNT);
  wire wr_stat  = bus_wr_go & hit(aw_addr_reg, `DPBR_OFF_STATUS);

  // Preload only lands while configuration is active
  wire preload_do = wr_ldata & cfg_mode;
  wire [`DPBR_DW-1:0] preload_word =
    lane_merge(mem[load_addr_reg], w_data_reg[15:0], w_strb_reg[1:0]);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= `DPBR_ADDR_RST;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `DPBR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (bus_wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        // Status is read-only; any other unlisted offset is an error too
        if (wr_ctrl || wr_laddr || wr_ldata || wr_wcnt || wr_rcnt || wr_bcnt)
          bresp_reg <= `DPBR_RESP_OKAY;
        else if (wr_stat)
          bresp_reg <= `DPBR_RESP_SLVERR;
        else
          bresp_reg <= `DPBR_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg      <= `DPBR_CTRL_RST;
      load_addr_reg <= `DPBR_ADDR_RST;
    end
    else
    begin
      if (wr_ctrl && w_strb_reg[0])
        ctrl_reg <= w_data_reg[`DPBR_CTRL_W-1:0];
      // Streaming preload: the pointer steps after each data word that lands in configuration
      if (wr_laddr && w_strb_reg[0])
        load_addr_reg <= w_data_reg[`DPBR_AW-1:0];
      else if (preload_do)
        load_addr_reg <= load_addr_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write: user port outside configuration, preload inside it

  // The two sources are exclusive through cfg_mode, so never collide
  always @(posedge aclk)
  begin
    if (wr_do)
      mem[wr_addr] <= wr_merged;
    else if (preload_do)
      mem[load_addr_reg] <= preload_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port register

  // No reset: undefined until the first enabled read
  always @(posedge aclk)
  begin
    if (rd_do)
      rd_data_reg <= mem[rd_addr];
  end

  assign rd_data = rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Activity counters; an event in the clearing cycle still counts

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_count_reg  <= `DPBR_CNT_RST;
      rd_count_reg  <= `DPBR_CNT_RST;
      blk_count_reg <= `DPBR_CNT_RST;
    end
    else
    begin
      if (wr_wcnt)
        wr_count_reg <= {{(`DPBR_CNT_W-1){1'b0}}, wr_do};
      else if (wr_do)
        wr_count_reg <= wr_count_reg + 16'h0001;
      if (wr_rcnt)
        rd_count_reg <= {{(`DPBR_CNT_W-1){1'b0}}, rd_do};
      else if (rd_do)
        rd_count_reg <= rd_count_reg + 16'h0001;
      if (wr_bcnt)
        blk_count_reg <= {{(`DPBR_CNT_W-1){1'b0}}, wr_blk};
      else if (wr_blk)
        blk_count_reg <= blk_count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status

  // Idle flag reflects the lowest-power state the user is advised to keep
  wire port_idle = ~wr_clk_gate & ~rd_clk_gate;

  wire [`DPBR_BUS_DW-1:0] status_word;
  assign status_word = {28'h0000000, rd_clk_inv, wr_clk_inv, port_idle, cfg_mode};

  ////////////////////////////////////////////////////////////////////////////
  // Bus read channel

  reg                      rvalid_reg;
  reg  [`DPBR_BUS_DW-1:0]  rdata_reg;
  reg  [1:0]               rresp_reg;
  reg  [`DPBR_BUS_DW-1:0]  rd_mux;
  reg  [1:0]               rd_resp_mux;

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always @*
  begin
    rd_mux      = 32'h00000000;
    rd_resp_mux = `DPBR_RESP_OKAY;
    if (hit(s_axi_araddr, `DPBR_OFF_CTRL))
      rd_mux = {29'h00000000, ctrl_reg};
    else if (hit(s_axi_araddr, `DPBR_OFF_LOAD_ADDR))
      rd_mux = {24'h000000, load_addr_reg};
    else if (hit(s_axi_araddr, `DPBR_OFF_LOAD_DATA))
      rd_mux = {16'h0000, mem[load_addr_reg]};
    else if (hit(s_axi_araddr, `DPBR_OFF_STATUS))
      rd_mux = status_word;
    else if (hit(s_axi_araddr, `DPBR_OFF_WR_COUNT))
      rd_mux = {16'h0000, wr_count_reg};
    else if (hit(s_axi_araddr, `DPBR_OFF_RD_COUNT))
      rd_mux = {16'h0000, rd_count_reg};
    else if (hit(s_axi_araddr, `DPBR_OFF_BLK_COUNT))
      rd_mux = {16'h0000, blk_count_reg};
    else
      rd_resp_mux = `DPBR_RESP_SLVERR;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `DPBR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_resp_mux;
      end
      else if (rvalid_reg && s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

endmodule // dpbr_block_ram

// File: verification/dpbr_fabric.sv
// Fabric-side user logic model driving the write and read ports
module dpbr_fabric
(
  // System and chosen idle level of both port clocks
  input  wire logic        aclk,
  input  wire logic        idle_lvl,
  // Write port
  output logic             wr_clk, wr_clk_gate, wr_port_on,
  output logic [7:0]       wr_addr,
  output logic [15:0]      wr_data, bit_write_inhibit,
  // Read port
  output logic             rd_clk, rd_clk_gate, rd_port_on,
  output logic [7:0]       rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {wr_clk, wr_clk_gate, wr_port_on, wr_addr, wr_data, bit_write_inhibit} = 43'h0;
    {rd_clk, rd_clk_gate, rd_port_on, rd_addr} = 11'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One clock pulse per operation; buses invert once released so stale
  // values are never mistaken for held ones
  task automatic wr(input logic [7:0] a, input logic [15:0] d, m, input logic g, e);
    @(posedge aclk);
    wr_clk <= idle_lvl;
    {wr_clk_gate, wr_port_on, wr_addr, wr_data, bit_write_inhibit} <= {g, e, a, d, m};
    @(posedge aclk);
    wr_clk <= ~idle_lvl;
    @(posedge aclk);
    wr_clk <= idle_lvl;
    {wr_clk_gate, wr_port_on, wr_addr, wr_data, bit_write_inhibit} <= {2'b00, ~a, ~d, ~m};
  endtask

  task automatic rd(input logic [7:0] a, input logic g, e);
    @(posedge aclk);
    rd_clk <= idle_lvl;
    {rd_clk_gate, rd_port_on, rd_addr} <= {g, e, a};
    @(posedge aclk);
    rd_clk <= ~idle_lvl;
    @(posedge aclk);
    rd_clk <= idle_lvl;
    {rd_clk_gate, rd_port_on, rd_addr} <= {2'b00, ~a};
  endtask
endmodule // dpbr_fabric

// File: verification/dpbr_block_ram_props.sv
// Bus handshake and read-port checks for the block RAM
module dpbr_block_ram_props
(
  // System
  input wire logic        aclk, aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  // Read port
  input wire logic        rd_clk, rd_clk_gate, rd_port_on,
  input wire logic [15:0] rd_data
);
  logic rd_clk_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Mirrors the design's previous sample, cleared in reset
  always @(posedge aclk)
    rd_clk_q <= aresetn ? rd_clk : 1'b0;

  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_late;
    ##2 s_axi_bvalid;
  endsequence

  b_answer_a: assert property (aw_w_taken |-> resp_late)
    else $error("write response late");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  aw_rearm_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channels not rearmed");
  ar_block_a: assert property (s_axi_arready != s_axi_rvalid)
    else $error("read ready not inverse of valid");
  rd_hold_a: assert property (!(rd_clk != rd_clk_q && rd_clk_gate && rd_port_on)
    |=> rd_data === $past(rd_data)) else $error("read data moved without read");
endmodule // dpbr_block_ram_props

bind dpbr_block_ram dpbr_block_ram_props u_props (.*);

// File: verification/dpbr_block_ram_tb.sv
// Self-checking bench for the dual-port block RAM
module dpbr_block_ram_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, idle_lvl = 1'b0, cfg = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pend = 1'b0, rprev = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        wr_clk, wr_clk_gate, wr_port_on, rd_clk, rd_clk_gate, rd_port_on;
  logic [7:0]  wr_addr, rd_addr;
  logic [15:0] wr_data, bit_write_inhibit, rd_data;
  logic [15:0] sh [256];
  logic [33:0] bq [$];
  logic [15:0] pq [$];
  int          fail_count = 0, comparisons = 0, nw = 0, nr = 0;
  int          seed = 32'hfe700c2b;

  dpbr_block_ram u_dut (.*);
  dpbr_fabric u_fab (.*);

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic tally(input logic ok, input logic [33:0] got, exp);
    comparisons++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_port(input logic [15:0] got, exp);
    tally(got === exp, {18'h0, got}, {18'h0, exp});
  endtask
  task automatic cmp_bus(input logic [33:0] got, exp);
    tally(got === exp, got, exp);
  endtask

  // Results come one edge after the enabled read edge or at bus handshakes
  always @(posedge aclk)
  begin
    if (pend)
      cmp_port(rd_data, pq.pop_front());
    pend = rd_clk_gate && rd_port_on && rd_clk !== rprev && rd_clk === ~idle_lvl;
    rprev = rd_clk;
    if (s_axi_bvalid && s_axi_bready)
      cmp_bus({s_axi_bresp, 32'h0}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      cmp_bus({s_axi_rresp, s_axi_rdata}, bq.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back({r, 32'h0});
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    bq.push_back(exp);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic pwr(input logic [7:0] a, input logic [15:0] d, m, input logic g, e);
    u_fab.wr(a, d, m, g, e);
    if (g && e && !cfg)
      sh[a] = (sh[a] & m) | (d & ~m);
    nw += int'(g && e && !cfg);
  endtask

  task automatic prd(input logic [7:0] a, input logic g, e);
    if (g && e)
      pq.push_back(sh[a]);
    nr += int'(g && e);
    u_fab.rd(a, g, e);
  endtask

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin : main
    logic [7:0] a;
    logic [15:0] d;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h00, 34'h0);
    axi_rd(8'h04, 34'h0);
    axi_rd(8'h0c, 34'h2);
    axi_rd(8'h1c, {2'h2, 32'h0});
    axi_wr(8'h0c, 32'h1, 2'h2);
    for (int i = 0; i < 8; i++)
    begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      d = 16'($random(seed));
      pwr(a, d, 16'h0, 1'b1, 1'b1);
      pwr(a, ~d, 16'($random(seed)), 1'b1, 1'b1);
      pwr(a, 16'h0, 16'h0, 1'b0, 1'b1);
      pwr(a, 16'h0, 16'h0, 1'b1, 1'b0);
      prd(a, 1'b1, 1'b0);
      prd(a, 1'b0, 1'b1);
      prd(a, 1'b1, 1'b1);
    end
    axi_rd(8'h10, 34'(nw));
    axi_rd(8'h14, 34'(nr));
    axi_wr(8'h10, 32'h0, 2'h0);
    axi_rd(8'h10, 34'h0);
    axi_wr(8'h14, 32'h0, 2'h0);
    axi_rd(8'h14, 34'h0);
    // Configuration window: port writes refused, preload over the bus
    axi_wr(8'h00, 32'h4, 2'h0);
    cfg = 1'b1;
    pwr(a, 16'hbeef, 16'h0, 1'b1, 1'b1);
    axi_wr(8'h04, 32'h55, 2'h0);
    axi_wr(8'h08, 32'h1234, 2'h0);
    sh[8'h55] = 16'h1234;
    axi_rd(8'h04, 34'h56);
    axi_wr(8'h04, 32'h55, 2'h0);
    axi_rd(8'h08, 34'h1234);
    axi_rd(8'h18, 34'h1);
    axi_wr(8'h18, 32'h0, 2'h0);
    axi_rd(8'h18, 34'h0);
    axi_rd(8'h0c, 34'h3);
    axi_wr(8'h00, 32'h3, 2'h0);
    cfg = 1'b0;
    // Preload outside configuration is acknowledged but must not land
    axi_wr(8'h08, 32'hffff, 2'h0);
    axi_rd(8'h04, 34'h55);
    @(posedge aclk);
    idle_lvl <= 1'b1;
    pwr(8'h55, 16'h5a5a, 16'hff00, 1'b1, 1'b1);
    prd(a, 1'b1, 1'b1);
    prd(8'h55, 1'b1, 1'b1);
    axi_rd(8'h0c, 34'he);
    axi_rd(8'h10, 34'h1);
    axi_rd(8'h14, 34'h2);
    repeat (3) @(posedge aclk);
    final_report();
  end

  initial
  begin : watchdog
    repeat (20000) @(posedge aclk);
    fail_count++;
    final_report();
  end
endmodule // dpbr_block_ram_tb
